// ### core/wwd_pkg.sv
package wwd_pkg;
	// timing: the watchdog time base is a divided enable off MCLK
	localparam int CLK_PERIOD_NS  = 50;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CFG1  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_MASK  = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;

	// watchdog_control fields
	localparam int CTRL_ON_BIT  = 15;
	localparam int CTRL_PS_LSB  = 2;
	localparam int CTRL_WIN_BIT = 1;
	localparam int CTRL_CLR_BIT = 0;

	// device_config_word_one fields
	localparam int CFG_WINSZ_LSB  = 24;
	localparam int CFG_EN_BIT     = 23;
	localparam int CFG_WINDOW_DISABLE_CFG_BIT = 22;
	localparam int CFG_PS_LSB     = 16;

	// postscale and window encodings
	localparam logic [4:0] PS_MAX    = 5'h14;
	localparam logic [1:0] WIN_25    = 2'h3;
	localparam logic [1:0] WIN_37P5  = 2'h2;
	localparam logic [1:0] WIN_50    = 2'h1;
	localparam int         CNT_W     = 21;

	// interrupt status / mask bits
	localparam int STAT_W           = 2;
	localparam int STAT_TIMEOUT_BIT = 0;
	localparam int STAT_EARLY_BIT   = 1;

	// reset values
	localparam logic        CTRL_ON_RESET  = 1'b0;
	localparam logic        CTRL_WIN_RESET = 1'b0;
	localparam logic [1:0]  STAT_RESET     = 2'h0;
	localparam logic [1:0]  MASK_RESET     = 2'h0;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] win_size;
		logic       enable;
		logic       win_disable;
		logic [4:0] postscale;
	} wwd_cfg_t;
endpackage

// ### core/wwd_top.sv
`timescale 1ns/1ps
module wwd_top
	import wwd_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input  wire logic        MCLK,          // 20 mhz clock
	input  wire logic        RESET_N,       // async reset, active low
	input  wire logic [31:0] CFG_WORD,      // nonvolatile configuration word
	input  wire logic [7:0]  S_AXI_AWADDR,  // write address
	input  wire logic        S_AXI_AWVALID, // write address valid
	output logic             S_AXI_AWREADY, // write address ready
	input  wire logic [31:0] S_AXI_WDATA,   // write data
	input  wire logic [3:0]  S_AXI_WSTRB,   // byte enables
	input  wire logic        S_AXI_WVALID,  // write data valid
	output logic             S_AXI_WREADY,  // write data ready
	output logic [1:0]       S_AXI_BRESP,   // write response
	output logic             S_AXI_BVALID,  // write response valid
	input  wire logic        S_AXI_BREADY,  // write response ready
	input  wire logic [7:0]  S_AXI_ARADDR,  // read address
	input  wire logic        S_AXI_ARVALID, // read address valid
	output logic             S_AXI_ARREADY, // read address ready
	output logic [31:0]      S_AXI_RDATA,   // read data
	output logic [1:0]       S_AXI_RRESP,   // read response
	output logic             S_AXI_RVALID,  // read data valid
	input  wire logic        S_AXI_RREADY,  // read data ready
	output logic             IRQ,           // level interrupt
	output logic             WDT_RESET_REQ  // one-cycle device reset request
);

	// reset release through two flops
	// assertion is immediate; release is retimed so no flop sees it mid-edge
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// configuration word crosses in from outside: two flops, second one read only
	logic [31:0] cfg_meta_reg;
	logic [31:0] cfg_sync_reg;
	wwd_cfg_t    cfg;

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cfg_meta_reg <= WORD_ZERO;
			cfg_sync_reg <= WORD_ZERO;
		end else begin
			cfg_meta_reg <= CFG_WORD;
			cfg_sync_reg <= cfg_meta_reg;
		end
	end

	assign cfg.win_size    = cfg_sync_reg[CFG_WINSZ_LSB +: 2];
	assign cfg.enable      = cfg_sync_reg[CFG_EN_BIT];
	assign cfg.win_disable = cfg_sync_reg[CFG_WINDOW_DISABLE_CFG_BIT];
	assign cfg.postscale   = cfg_sync_reg[CFG_PS_LSB +: 5];

	// ---------------- axi4-lite slave ----------------
	logic        aw_have_reg, aw_have_next;
	logic        w_have_reg, w_have_next;
	logic [7:0]  aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0]  w_strb_reg, w_strb_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        wr_fire;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_hit;

	assign S_AXI_AWREADY = ~aw_have_reg & ~bvalid_reg;
	assign S_AXI_WREADY  = ~w_have_reg & ~bvalid_reg;
	assign S_AXI_ARREADY = ~rvalid_reg;
	assign S_AXI_BVALID  = bvalid_reg;
	assign S_AXI_BRESP   = bresp_reg;
	assign S_AXI_RVALID  = rvalid_reg;
	assign S_AXI_RRESP   = rresp_reg;
	assign S_AXI_RDATA   = rdata_reg;
	// a write lands once both address and data are held, in whichever order they came
	assign wr_fire       = aw_have_reg & w_have_reg;
	// config word and count are read-only, so writes there answer slverr
	assign wr_hit        = (aw_addr_reg == OFS_CTRL) | (aw_addr_reg == OFS_STAT) | (aw_addr_reg == OFS_MASK);

	// watchdog state seen by the read mux
	logic              sw_on_reg, sw_on_next;
	logic              win_en_reg, win_en_next;
	logic [4:0]        ps_shadow_reg, ps_shadow_next;
	logic              loaded_reg, loaded_next;
	logic [STAT_W-1:0] stat_reg, stat_next;
	logic [STAT_W-1:0] mask_reg, mask_next;
	logic [CNT_W-1:0]  count_reg, count_next;
	logic              running;

	// read mux; unmapped addresses answer zero with slverr
	always_comb begin
		rd_word = WORD_ZERO;
		rd_hit  = 1'b1;
		case (S_AXI_ARADDR)
			OFS_CTRL: begin
				rd_word[CTRL_ON_BIT]           = running;
				rd_word[CTRL_PS_LSB +: 5]      = ps_shadow_reg;
				rd_word[CTRL_WIN_BIT]          = win_en_reg;
			end
			OFS_CFG1:  rd_word = cfg_sync_reg;
			OFS_STAT:  rd_word[STAT_W-1:0] = stat_reg;
			OFS_MASK:  rd_word[STAT_W-1:0] = mask_reg;
			OFS_COUNT: rd_word[CNT_W-1:0] = count_reg;
			default:   rd_hit = 1'b0;
		endcase
	end

	// bus handshake next state
	// readys fall while a response waits, so at most one write and one read are open
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_have_next = 1'b1;
			aw_addr_next = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_have_next = 1'b1;
			w_data_next = S_AXI_WDATA;
			w_strb_next = S_AXI_WSTRB;
		end
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && S_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_word;
			rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= WORD_ZERO;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= WORD_ZERO;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ---------------- control registers ----------------
	logic       wr_ctrl;
	logic       clr_strobe;
	logic       windowed;
	logic       early_clear;
	logic       timeout;
	logic [1:0] cfg_age_reg, cfg_age_next;
	logic       cfg_ready;

	assign wr_ctrl    = wr_fire & (aw_addr_reg == OFS_CTRL);
	// clear is a strobe: it is never stored, so it always reads back zero
	assign clr_strobe = wr_ctrl & w_strb_reg[0] & w_data_reg[CTRL_CLR_BIT];
	// configuration enable forces the watchdog on; when it is clear the software bit decides
	assign running    = cfg.enable | sw_on_reg;
	// the synced word holds reset zeros for two edges after release;
	// the shadow waits for it so it never captures those zeros
	assign cfg_ready  = cfg_age_reg[1];

	// control, status and mask next state
	always_comb begin
		sw_on_next     = sw_on_reg;
		win_en_next    = win_en_reg;
		ps_shadow_next = ps_shadow_reg;
		cfg_age_next   = {cfg_age_reg[0], 1'b1};
		loaded_next    = loaded_reg | cfg_ready;
		stat_next      = stat_reg;
		mask_next      = mask_reg;
		// shadow copy taken once the synced configuration is valid after reset
		if (!loaded_reg && cfg_ready) begin
			ps_shadow_next = cfg.postscale;
		end
		if (wr_ctrl && w_strb_reg[1]) begin
			sw_on_next = w_data_reg[CTRL_ON_BIT];
		end
		if (wr_ctrl && w_strb_reg[0]) begin
			win_en_next = w_data_reg[CTRL_WIN_BIT];
		end
		if (wr_fire && (aw_addr_reg == OFS_MASK) && w_strb_reg[0]) begin
			mask_next = w_data_reg[STAT_W-1:0];
		end
		// write-one-to-clear, then hardware sets so a same-cycle event wins
		if (wr_fire && (aw_addr_reg == OFS_STAT) && w_strb_reg[0]) begin
			stat_next = stat_next & ~w_data_reg[STAT_W-1:0];
		end
		stat_next[STAT_TIMEOUT_BIT] = stat_next[STAT_TIMEOUT_BIT] | timeout;
		stat_next[STAT_EARLY_BIT]   = stat_next[STAT_EARLY_BIT] | early_clear;
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			sw_on_reg     <= CTRL_ON_RESET;
			win_en_reg    <= CTRL_WIN_RESET;
			ps_shadow_reg <= 5'h00;
			loaded_reg    <= 1'b0;
			cfg_age_reg   <= 2'b00;
			stat_reg      <= STAT_RESET;
			mask_reg      <= MASK_RESET;
		end else begin
			sw_on_reg     <= sw_on_next;
			win_en_reg    <= win_en_next;
			ps_shadow_reg <= ps_shadow_next;
			loaded_reg    <= loaded_next;
			cfg_age_reg   <= cfg_age_next;
			stat_reg      <= stat_next;
			mask_reg      <= mask_next;
		end
	end

	// level output: high until software clears the status bit or masks it
	assign IRQ = |(stat_reg & mask_reg);

	// ---------------- watchdog counter ----------------
	logic [15:0]      tick_cnt_reg, tick_cnt_next;
	logic             tick;
	logic [4:0]       ps_eff;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] win_len;
	logic [CNT_W-1:0] win_open;
	logic             reset_req_reg, reset_req_next;

	// shadow is not usable until loaded, so the count holds until then
	// codes past the table clamp; an unclamped shift would wrap to a zero period
	assign ps_eff   = (ps_shadow_reg > PS_MAX) ? PS_MAX : ps_shadow_reg;
	assign period   = CNT_W'(1) << ps_eff;
	// either the control bit or a cleared window-disable strap selects window mode
	assign windowed = win_en_reg | ~cfg.win_disable;
	assign tick     = (tick_cnt_reg == 16'(TICK_DIV - 1));

	// clear window length as a fraction of the period; small periods truncate
	// 37.5 percent is a quarter plus an eighth, so no divider is needed
	always_comb begin
		case (cfg.win_size)
			WIN_25:   win_len = period >> 2;
			WIN_37P5: win_len = (period >> 2) + (period >> 3);
			WIN_50:   win_len = period >> 1;
			default:  win_len = (period >> 1) + (period >> 2);
		endcase
		win_open = period - win_len;
	end

	// an early clear counts as a timeout: both status bits and the pulse follow
	assign early_clear = running & loaded_reg & windowed & clr_strobe & (count_reg < win_open);
	assign timeout     = early_clear
		| (running & loaded_reg & tick & ~clr_strobe & (count_reg >= period - CNT_W'(1)));

	// time base divider and postscaled count
	// stopping restarts the divider, so every start gives a full first period
	// a clear in the same cycle as a tick wins over the increment
	always_comb begin
		tick_cnt_next  = tick_cnt_reg;
		count_next     = count_reg;
		reset_req_next = timeout;
		if (!running || !loaded_reg) begin
			tick_cnt_next = 16'h0000;
			count_next    = {CNT_W{1'b0}};
		end else begin
			tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
			if (clr_strobe || timeout) begin
				count_next = {CNT_W{1'b0}};
			end else if (tick) begin
				count_next = count_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg  <= 16'h0000;
			count_reg     <= {CNT_W{1'b0}};
			reset_req_reg <= 1'b0;
		end else begin
			tick_cnt_reg  <= tick_cnt_next;
			count_reg     <= count_next;
			reset_req_reg <= reset_req_next;
		end
	end

	// registered so the reset request is glitch free
	assign WDT_RESET_REQ = reset_req_reg;

endmodule

// ### verif/wwd_props.sv
`timescale 1ns/1ps
module wwd_props
	import wwd_pkg::*;
(
	input wire logic        MCLK,          // clock
	input wire logic        RESET_N,       // reset
	input wire logic [7:0]  S_AXI_AWADDR,  // aw
	input wire logic        S_AXI_AWVALID, // aw
	input wire logic        S_AXI_AWREADY, // aw
	input wire logic        S_AXI_WVALID,  // w
	input wire logic        S_AXI_WREADY,  // w
	input wire logic [1:0]  S_AXI_BRESP,   // b
	input wire logic        S_AXI_BVALID,  // b
	input wire logic        S_AXI_BREADY,  // b
	input wire logic        S_AXI_ARVALID, // ar
	input wire logic        S_AXI_ARREADY, // ar
	input wire logic [31:0] S_AXI_RDATA,   // r
	input wire logic        S_AXI_RVALID,  // r
	input wire logic        S_AXI_RREADY,  // r
	input wire logic        WDT_RESET_REQ  // timeout
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// both write halves taken on one edge; the response shows two edges later
	sequence s_wr;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_rd;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	a_wr_answer: assert property (s_wr |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	a_bad_write: assert property (s_wr ##0 S_AXI_AWADDR > OFS_COUNT |-> ##2 S_AXI_BRESP == RESP_SLVERR)
		else $error("unmapped write not refused");
	a_ctrl_okay: assert property (s_wr ##0 S_AXI_AWADDR == OFS_CTRL |-> ##2 S_AXI_BRESP == RESP_OKAY)
		else $error("control write refused");
	a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	a_rd_answer: assert property (s_rd |=> S_AXI_RVALID)
		else $error("read answer late");
	a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read accepted while busy");
	a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted while busy");
	a_req_pulse: assert property (WDT_RESET_REQ |=> !WDT_RESET_REQ)
		else $error("reset request too long");
endmodule
bind wwd_top wwd_props wwd_props_i (.MCLK(MCLK), .RESET_N(RESET_N), .S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
	.WDT_RESET_REQ(WDT_RESET_REQ));

// ### verif/wwd_top_tb.sv
`timescale 1ns/1ps
module wwd_top_tb;
	import wwd_pkg::*;
	localparam int TD = 2;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic [31:0] cfgw = WORD_ZERO, wd = WORD_ZERO, rv, rdat;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic        awr, wr_rdy, bv, arr, rvl, irq, req;
	logic [1:0]  br, rr, bresp, rresp;
	int          failures = 0, samples_checked = 0, pulses = 0, cyc = 0, t0 = 0, t1 = 0, n;
	int          thr[4] = '{8, 16, 20, 24};
	wwd_top #(.TICK_DIV(TD)) wwd_top_i (.MCLK(clk), .RESET_N(rst_n), .CFG_WORD(cfgw),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvl),
		.S_AXI_RREADY(rrd), .IRQ(irq), .WDT_RESET_REQ(req));
	always #25 clk = ~clk;
	// counts timeout pulses and the cycle of the last two
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (req === 1'b1) begin
			pulses <= pulses + 1;
			t0 <= t1;
			t1 <= cyc;
		end
	end
	function automatic logic [31:0] cw(logic [1:0] sz, logic en, logic wdis, logic [4:0] ps);
		return {6'h00, sz, en, wdis, 1'h0, ps, 16'h0000};
	endfunction
	task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	// postscale in the config word only lands through a reset
	task automatic rst(input logic [31:0] c);
		@(posedge clk) rst_n <= 1'b0;
		cfgw <= c;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wr_rdy === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
		brd <= 1'b0;
		br = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk) ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		do begin
			@(posedge clk);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rvl !== 1'b1);
		rrd <= 1'b0;
		rv = rdat;
		rr = rresp;
	endtask
	// bounded wait for the next timeout pulse
	task automatic wp();
		n = pulses;
		for (int i = 0; i < 200 && pulses == n; i++) @(posedge clk);
	endtask
	task automatic stop_test();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// hang guard, far beyond the little over a thousand cycles needed
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		stop_test();
	end
	initial begin
		rst(cw(2'h0, 1'b0, 1'b1, 5'h1F));
		rd(OFS_CTRL); ck("ctrl", 32'h0000_007C, rv);
		rd(OFS_CFG1); ck("cfg", cfgw, rv);
		rd(OFS_COUNT); ck("count", 32'h0000_0000, rv);
		rd(OFS_MASK); ck("mask", 32'h0000_0000, rv);
		rd(8'h20); ck("rresp", 32'(RESP_SLVERR), 32'(rr));
		wr(8'h20, 32'h0000_0001); ck("bresp", 32'(RESP_SLVERR), 32'(br));
		// an out-of-table code must act as the largest period, so its window opens late
		wr(OFS_CTRL, 32'h0000_8002);
		n = pulses;
		wr(OFS_CTRL, 32'h0000_8003);
		repeat (3) @(posedge clk);
		ck("clamp", 32'(n + 1), 32'(pulses));
		$display("end reset_values");
		rst(cw(2'h0, 1'b0, 1'b1, 5'h04));
		wr(OFS_MASK, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_8000);
		rd(OFS_CTRL); ck("on", 32'h0000_8010, rv);
		wp(); ck("irq", 32'h1, 32'(irq));
		wr(OFS_STAT, 32'h0000_0001); ck("irq", 32'h0, 32'(irq));
		wr(OFS_MASK, 32'h0000_0000);
		wp(); ck("irq", 32'h0, 32'(irq));
		ck("period", 32'(16 * TD), 32'(t1 - t0));
		rd(OFS_STAT); ck("stat", 32'h0000_0001, rv);
		wr(OFS_CTRL, 32'h0000_0000);
		@(posedge clk);
		n = pulses;
		repeat (80) @(posedge clk);
		ck("off", 32'(n), 32'(pulses));
		wr(OFS_CTRL, 32'h0000_8000);
		// clearing often keeps it quiet, zero in the strobe does not
		for (int v = 1; v >= 0; v--) begin
			n = pulses;
			repeat (12) wr(OFS_CTRL, 32'h0000_8000 | 32'(v));
			ck("clr", 32'(v), 32'(pulses == n));
		end
		$display("end software_enable");
		foreach (thr[k]) begin
			rst(cw(2'(3 - k), 1'b1, 1'b1, 5'(2 * k)));
			wp();
			wp();
			if (k < 3) ck("period", 32'((2 ** (2 * k)) * TD), 32'(t1 - t0));
		end
		rd(OFS_CTRL); ck("on", 32'h0000_8018, rv);
		wr(OFS_CTRL, 32'h0000_0000);
		rd(OFS_CTRL); ck("on", 32'h0000_8018, rv);
		wp(); ck("run", 32'(n + 1), 32'(pulses));
		$display("end config_enable");
		for (int k = 0; k < 4; k++) begin
			rst(cw(2'(k), 1'b1, 1'b0, 5'h05));
			do rd(OFS_COUNT); while (rv < 32'(thr[k]));
			n = pulses;
			wr(OFS_CTRL, 32'h0000_0001);
			wr(OFS_CTRL, 32'h0000_0001);
			repeat (3) @(posedge clk);
			ck("early", 32'(n + 1), 32'(pulses));
			rd(OFS_STAT); ck("stat", 32'h0000_0003, rv);
		end
		rst(cw(2'h3, 1'b1, 1'b1, 5'h05));
		wr(OFS_CTRL, 32'h0000_0002);
		rd(OFS_CTRL); ck("win", 32'h0000_8016, rv);
		n = pulses;
		wr(OFS_CTRL, 32'h0000_0003);
		repeat (3) @(posedge clk);
		ck("early", 32'(n + 1), 32'(pulses));
		$display("end window");
		stop_test();
	end
endmodule
